// ===== verilog/nvm_i2c_pkg.sv
// What this block does
// RL1 - Serve as bus slave at 100 kHz and 1 MHz clock rates.
// RL2 - Ignore any pulse on data or clock shorter than 50 ns.
// RL3 - Answer only the fixed 7-bit slave address; ignore others.
// RL4 - Data changes only while clock low; one clock pulse per bit.
// RL5 - Detect start and stop: data falling or rising while clock high.
// RL6 - Bytes are eight bits, most significant first, then one acknowledge.
// RL7 - Receiver drives acknowledge on ninth pulse; low acks, high does not.
// RL8 - Compare address byte after start; acknowledge only on match, else idle.
// RL9 - Master ends a write with stop after last acknowledge.
// RL10 - On master not-acknowledge in a read, release data and go idle.
// RL11 - First write byte sets pointer; later bytes stored, pointer advances.
// RL12 - Read returns successive bytes from pointer while master acknowledges.
// RL13 - Writing copy bit copies all registers into the shadow SRAM.
// RL14 - SRAM data writes store at memory address, then advance it.
// RL15 - SRAM data reads return byte at memory address, then advance it.
// RL16 - EEPROM data reads return byte at memory address, then advance it.
// RL17 - Program bit copies SRAM into EEPROM only while unlock key held.
// RL18 - Busy bit reads one while programming; EEPROM access then blocked.
// RL19 - Program count increments once per completed programming cycle.
// RL20 - Host writes zero to unlock register after programming.
// RL21 - Host avoids two successive accesses to the memory address register.
// RL22 - At reset, registers load from the stored EEPROM configuration.
// RL23 - Never stretch clock; drive data only for acknowledge and read data.
// Purpose: Constants and types for the serial slave with memory programmer.
// Assumes: One 250 MHz system clock.
// Notes:   Register offsets are byte addresses on the serial bus.
package nvm_i2c_pkg;
  localparam logic [6:0] SLAVE_ADDR      = 7'h59;
  localparam logic [7:0] OFF_PROG_COUNT  = 8'h30;
  localparam logic [7:0] OFF_NVM_CTRL    = 8'h31;
  localparam logic [7:0] OFF_MEM_ADDR    = 8'h33;
  localparam logic [7:0] OFF_EE_DATA     = 8'h34;
  localparam logic [7:0] OFF_SRAM_DATA   = 8'h35;
  localparam logic [7:0] OFF_UNLOCK      = 8'h38;
  localparam logic [7:0] UNLOCK_KEY      = 8'hBE;
  localparam int         BIT_PROG        = 0;
  localparam int         BIT_BUSY        = 2;
  localparam int         BIT_COPY        = 6;
  localparam int         CLK_MHZ         = 250;
  localparam int         GLITCH_NS       = 50;
  // Filter length in cycles, rounded up, at least one.
  localparam int         GLITCH_CYC      = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;
  localparam logic [3:0] LAST_BIT        = 4'h7;
  localparam logic [3:0] ACK_BIT         = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_WRITE, ST_READ, ST_SKIP
  } bus_state_e;

  // Filtered bus lines travel together.
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_s;
endpackage

// ===== verilog/i2c_slave_nvm_programmer.sv
// Purpose: Serial slave with register file, shadow SRAM and EEPROM copy.
// Assumes: Bus lines are open drain, sampled by the system clock.
// Notes:   Clock line is never stretched; program cycle time is a parameter.
//          Both pins pass a two-stage synchroniser and a glitch filter, so
//          every bus event reaches the engine some 15 system cycles late.
//          That lag is far below a bus clock phase, so sampling at the
//          filtered rise still sees settled data.
//          Data bytes are committed at the eighth clock rise, before the
//          acknowledge, so a write takes effect even if the master stops
//          right after the acknowledge pulse.
`timescale 1ns/1ns
module i2c_slave_nvm_programmer #(
  parameter int REG_COUNT  = 64,
  parameter int PROG_CYCLES = 16
) (
  // Clock and reset.
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  // Serial bus pins; the data enable is low while the pin is driven.
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  // Status for the surrounding device.
  output logic            prog_busy_out,
  output logic [7:0]      prog_count_out
);
  localparam int AW = $clog2(REG_COUNT);

  // The byte-wide pointer is compared against the array size, so the size
  // must fit in a byte. Index slicing needs a power of two, so that every
  // memory address maps onto a real entry. The program timer is 16 bits.
  initial begin
    if (REG_COUNT < 64 || REG_COUNT > 128 ||
        (REG_COUNT & (REG_COUNT - 1)) != 0 ||
        PROG_CYCLES < 1 || PROG_CYCLES > 65536) begin
      $error("Unsupported parameter values.");
    end
  end

  // Two-stage synchronisers for both pins.
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
    end
  end

  // Glitch filters accept a new level only after it stands for 50 ns.
  nvm_i2c_pkg::bus_lines_s filt_q;
  nvm_i2c_pkg::bus_lines_s filt_prev_q;
  logic [1:0] raw;
  logic [1:0] filt_v;
  assign raw = {scl_sync_q[1], sda_sync_q[1]};
  assign filt_v = {filt_q.scl, filt_q.sda};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      logic [7:0] cnt_q;
      logic       lvl_q;
      always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
          cnt_q <= 8'h00;
          lvl_q <= 1'b1;
        end else if (raw[g] == lvl_q) begin
          cnt_q <= 8'h00;
        end else if (cnt_q >= 8'(nvm_i2c_pkg::GLITCH_CYC - 1)) begin
          lvl_q <= raw[g]; // [RL2]
          cnt_q <= 8'h00;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  endgenerate
  assign filt_q = {g_filt[1].lvl_q, g_filt[0].lvl_q};

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      filt_prev_q <= 2'h3;
    end else begin
      filt_prev_q <= filt_q;
    end
  end

  // Edge and condition detection on the filtered lines.
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise = filt_q.scl && !filt_prev_q.scl; // [RL4]
  assign scl_fall = !filt_q.scl && filt_prev_q.scl;
  assign start_cond = filt_q.scl && filt_prev_q.scl &&
                      filt_prev_q.sda && !filt_q.sda; // [RL5]
  assign stop_cond = filt_q.scl && filt_prev_q.scl &&
                     !filt_prev_q.sda && filt_q.sda; // [RL5]

  // Storage: register file, shadow SRAM, EEPROM, all as flip-flops.
  logic [7:0] regs_q   [REG_COUNT];
  logic [7:0] sram_q   [REG_COUNT];
  logic [7:0] eeprom_q [REG_COUNT];

  nvm_i2c_pkg::bus_state_e state_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic       ptr_set_q;
  logic       ack_q;
  logic       drive_q;
  logic [7:0] tx_q;
  logic [7:0] mem_addr_q;
  logic [7:0] unlock_q;
  logic [7:0] count_q;
  logic       busy_q;
  logic [15:0] prog_cnt_q;
  logic       load_q;

  // Read decode, shared by the first read byte and every later one.
  function automatic logic [7:0] read_reg(input logic [7:0] a);
    logic [7:0] v;
    v = nvm_i2c_pkg::ZERO_BYTE;
    if (a == nvm_i2c_pkg::OFF_PROG_COUNT) begin
      v = count_q;
    end else if (a == nvm_i2c_pkg::OFF_NVM_CTRL) begin
      v[nvm_i2c_pkg::BIT_BUSY] = busy_q; // [RL18]
    end else if (a == nvm_i2c_pkg::OFF_MEM_ADDR) begin
      v = mem_addr_q;
    end else if (a == nvm_i2c_pkg::OFF_EE_DATA) begin
      // Reads zero while programming is busy. [RL18]
      v = busy_q ? nvm_i2c_pkg::ZERO_BYTE
                 : eeprom_q[mem_addr_q[AW-1:0]]; // [RL16]
    end else if (a == nvm_i2c_pkg::OFF_SRAM_DATA) begin
      v = sram_q[mem_addr_q[AW-1:0]]; // [RL15]
    end else if (a == nvm_i2c_pkg::OFF_UNLOCK) begin
      v = unlock_q;
    end else if (a < 8'(REG_COUNT)) begin
      v = regs_q[a[AW-1:0]];
    end
    return v;
  endfunction

  // Events from the bus to the storage side.
  logic       wr_byte;
  logic       rd_byte;
  logic [7:0] acc_addr;
  assign acc_addr = ptr_q;

  // Complete received byte at the eighth rise: seven bits already shifted
  // in plus the bit being sampled now. Using the shift register alone here
  // would drop the last bit of every stored byte.
  logic [7:0] wr_data;
  assign wr_data = {shift_q[6:0], filt_q.sda};

  // Byte that the pointer selects, loaded when a read byte begins.
  // A process is used so the decode follows every storage element that
  // the function reads, not only its argument.
  logic [7:0] rd_val;
  always_comb begin
    rd_val = read_reg(ptr_q);
  end
  assign wr_byte = (state_q == nvm_i2c_pkg::ST_WRITE) && scl_rise &&
                   bit_q == nvm_i2c_pkg::LAST_BIT && ptr_set_q;
  // A read byte is consumed when the master acknowledges it.
  assign rd_byte = (state_q == nvm_i2c_pkg::ST_READ) && scl_rise &&
                   bit_q == nvm_i2c_pkg::ACK_BIT && !filt_q.sda;

  // Bus protocol engine: address, pointer, write and read bytes.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_q   <= nvm_i2c_pkg::ST_IDLE;
      bit_q     <= 4'h0;
      shift_q   <= 8'h00;
      ptr_q     <= 8'h00;
      ptr_set_q <= 1'b0;
      ack_q     <= 1'b0;
    end else if (start_cond) begin
      state_q   <= nvm_i2c_pkg::ST_ADDR;
      bit_q     <= 4'h0;
      ptr_set_q <= 1'b0;
    end else if (stop_cond) begin
      state_q <= nvm_i2c_pkg::ST_IDLE;
    end else if (scl_rise) begin
      case (state_q)
        nvm_i2c_pkg::ST_ADDR, nvm_i2c_pkg::ST_WRITE: begin
          if (bit_q <= nvm_i2c_pkg::LAST_BIT) begin
            shift_q <= {shift_q[6:0], filt_q.sda}; // [RL6]
          end
          bit_q <= (bit_q == nvm_i2c_pkg::ACK_BIT) ? 4'h0 : bit_q + 4'h1;
          if (bit_q == nvm_i2c_pkg::LAST_BIT && state_q ==
              nvm_i2c_pkg::ST_WRITE) begin
            if (!ptr_set_q) begin
              ptr_q     <= {shift_q[6:0], filt_q.sda}; // [RL11]
              ptr_set_q <= 1'b1;
            end else begin
              ptr_q <= ptr_q + 8'h01; // [RL11]
            end
          end
          if (bit_q == nvm_i2c_pkg::LAST_BIT &&
              state_q == nvm_i2c_pkg::ST_ADDR) begin
            ack_q <= (shift_q[6:0] == nvm_i2c_pkg::SLAVE_ADDR); // [RL3]
          end
          if (bit_q == nvm_i2c_pkg::ACK_BIT &&
              state_q == nvm_i2c_pkg::ST_ADDR) begin
            if (!ack_q) begin
              state_q <= nvm_i2c_pkg::ST_SKIP; // [RL8]
            end else if (shift_q[0]) begin
              state_q <= nvm_i2c_pkg::ST_READ; // [RL12]
            end else begin
              state_q <= nvm_i2c_pkg::ST_WRITE;
            end
          end
        end
        nvm_i2c_pkg::ST_READ: begin
          bit_q <= (bit_q == nvm_i2c_pkg::ACK_BIT) ? 4'h0 : bit_q + 4'h1;
          if (bit_q == nvm_i2c_pkg::ACK_BIT) begin
            if (filt_q.sda) begin
              state_q <= nvm_i2c_pkg::ST_SKIP; // [RL10]
            end else begin
              ptr_q <= ptr_q + 8'h01; // [RL12]
            end
          end
        end
        default: begin
          bit_q <= 4'h0;
        end
      endcase
    end
  end

  // Data output: ack and read bits change only after the clock falls.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || start_cond || stop_cond) begin
      drive_q <= 1'b0;
      tx_q    <= 8'h00;
    end else if (scl_fall) begin
      drive_q <= 1'b0; // [RL23]
      if (bit_q == nvm_i2c_pkg::ACK_BIT &&
          (state_q == nvm_i2c_pkg::ST_WRITE ||
           (state_q == nvm_i2c_pkg::ST_ADDR && ack_q))) begin
        drive_q <= 1'b1; // [RL7]
      end
      if (bit_q == 4'h0 && state_q == nvm_i2c_pkg::ST_READ) begin
        // The most significant bit goes out first. [RL6]
        tx_q    <= rd_val;
        drive_q <= !rd_val[7]; // [RL6]
      end else if (state_q == nvm_i2c_pkg::ST_READ &&
                   bit_q <= nvm_i2c_pkg::LAST_BIT) begin
        tx_q    <= {tx_q[6:0], 1'b0};
        drive_q <= !tx_q[6];
      end
    end
  end
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = !drive_q;

  // Memory address register, unlock key and auto-advance on data access.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      mem_addr_q <= 8'h00;
      unlock_q   <= 8'h00;
    end else if ((wr_byte && (acc_addr == nvm_i2c_pkg::OFF_SRAM_DATA)) ||
                 (rd_byte && (acc_addr == nvm_i2c_pkg::OFF_SRAM_DATA ||
                  (acc_addr == nvm_i2c_pkg::OFF_EE_DATA && !busy_q)))) begin
      mem_addr_q <= mem_addr_q + 8'h01; // [RL14] [RL15] [RL16]
    end else if (wr_byte) begin
      if (acc_addr == nvm_i2c_pkg::OFF_MEM_ADDR) begin
        // A second address write simply replaces the first. [RL21]
        mem_addr_q <= wr_data; // [RL21]
      end else if (acc_addr == nvm_i2c_pkg::OFF_UNLOCK) begin
        // Any value but the key locks programming again. [RL20]
        unlock_q <= wr_data; // [RL20]
      end
    end
  end

  // Registers and SRAM; reset loads registers from EEPROM.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      load_q <= 1'b1;
    end else begin
      load_q <= 1'b0;
      for (int i = 0; i < REG_COUNT; i++) begin
        if (load_q) begin
          regs_q[i] <= eeprom_q[i]; // [RL22]
        end
      end
      if (wr_byte && acc_addr < 8'(REG_COUNT) &&
          acc_addr != nvm_i2c_pkg::OFF_PROG_COUNT &&
          acc_addr != nvm_i2c_pkg::OFF_EE_DATA) begin
        regs_q[acc_addr[AW-1:0]] <= wr_data; // [RL11]
      end
      // The copy takes the register values as they stood before this
      // byte, since the copy command itself is not part of the image.
      if (wr_byte && acc_addr == nvm_i2c_pkg::OFF_NVM_CTRL &&
          wr_data[nvm_i2c_pkg::BIT_COPY]) begin
        for (int i = 0; i < REG_COUNT; i++) begin
          sram_q[i] <= regs_q[i]; // [RL13]
        end
      end else if (wr_byte && acc_addr == nvm_i2c_pkg::OFF_SRAM_DATA) begin
        sram_q[mem_addr_q[AW-1:0]] <= wr_data; // [RL14]
      end
    end
  end

  // EEPROM program cycle, guarded by the unlock key.
  // The array is written in one step at the end of the timed cycle, so a
  // reset in mid-cycle leaves the old contents intact and uncounted.
  // Requests arriving while busy are ignored rather than queued.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      busy_q     <= 1'b0;
      prog_cnt_q <= 16'h0000;
      count_q    <= 8'h00;
    end else if (busy_q) begin
      if (prog_cnt_q == 16'(PROG_CYCLES - 1)) begin
        busy_q  <= 1'b0;
        count_q <= count_q + 8'h01; // [RL19]
        for (int i = 0; i < REG_COUNT; i++) begin
          eeprom_q[i] <= sram_q[i]; // [RL17]
        end
      end
      prog_cnt_q <= prog_cnt_q + 16'h0001;
    end else if (wr_byte && acc_addr == nvm_i2c_pkg::OFF_NVM_CTRL &&
                 wr_data[nvm_i2c_pkg::BIT_PROG] &&
                 unlock_q == nvm_i2c_pkg::UNLOCK_KEY) begin
      busy_q     <= 1'b1; // [RL17] [RL18]
      prog_cnt_q <= 16'h0000;
    end
  end
  assign prog_busy_out  = busy_q;
  assign prog_count_out = count_q;
  // Bus rate up to 1 MHz is served by the 250 MHz oversampling. [RL1]
endmodule

// ===== tb/i2c_slave_nvm_programmer_assertions.sv
// Purpose: Port checks for the serial slave with memory programmer.
// Assumes: Bench bus clock phases are longer than the input filter.
// Notes:   Bound to every instance of the top module below.
`timescale 1ns/1ns
module nvm_i2c_checker #(
  parameter int REG_COUNT   = 64,
  parameter int PROG_CYCLES = 16
) (
  input wire logic       sys_clk_in,
  input wire logic       reset_in,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n_out,
  input wire logic       prog_busy_out,
  input wire logic [7:0] prog_count_out
);
  logic [15:0] busy_q;
  logic [7:0]  high_q;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // Counts the cycles of one program run.
  always_ff @(posedge sys_clk_in) begin
    busy_q <= prog_busy_out ? busy_q + 16'h0001 : 16'h0000;
  end
  // Counts cycles of bus clock high, saturating, to spot an idle bus.
  always_ff @(posedge sys_clk_in) begin
    high_q <= (reset_in || !scl_in) ? 8'h00
            : high_q + {7'h00, high_q != 8'hFF};
  end
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("data output not held low");
  a_reset_state: assert property (disable iff (1'b0) reset_in |=>
    sda_oe_n_out && !prog_busy_out && prog_count_out == 8'h00)
    else $error("outputs not at rest after reset");
  a_busy_bound: assert property (busy_q <= PROG_CYCLES + 1)
    else $error("program run too long");
  a_busy_length: assert property ($fell(prog_busy_out) |->
    busy_q >= PROG_CYCLES - 1)
    else $error("program run too short");
  a_count_step: assert property ($changed(prog_count_out) &&
    !$past(reset_in) |-> prog_count_out == $past(prog_count_out) + 8'h01)
    else $error("program count not stepped by one");
  a_count_cause: assert property ($changed(prog_count_out) &&
    !$past(reset_in) |-> $past(prog_busy_out) || $past(prog_busy_out, 2))
    else $error("program count moved without a program run");
  a_drive_clk_low: assert property ($changed(sda_oe_n_out) |->
    !scl_in && !$past(scl_in, 4))
    else $error("data drive changed while bus clock high");
  a_idle_release: assert property (high_q > 8'h28 |-> sda_oe_n_out)
    else $error("data driven on an idle bus");
  c_program: cover property ($rose(prog_busy_out));
  c_ack: cover property ($fell(sda_oe_n_out));
  c_count: cover property ($changed(prog_count_out) && !reset_in);
endmodule

bind i2c_slave_nvm_programmer nvm_i2c_checker #(
  .REG_COUNT   (REG_COUNT),
  .PROG_CYCLES (PROG_CYCLES)
) chk (
  .sys_clk_in     (sys_clk_in),
  .reset_in       (reset_in),
  .scl_in         (scl_in),
  .sda_in         (sda_in),
  .sda_out        (sda_out),
  .sda_oe_n_out   (sda_oe_n_out),
  .prog_busy_out  (prog_busy_out),
  .prog_count_out (prog_count_out)
);

// ===== tb/bus_host_model.sv
// Purpose: Behavioural bus master owning the clock and its data drive.
// Assumes: Data line has a pull-up, so a released line reads high.
// Notes:   Quarter bit of 64 ns keeps each phase above the filter.
`timescale 1ns/1ns
module bus_host_model (
  // Wired data line level.
  input  wire logic sda_line_in,
  // Master pins; clock stands high outside frames.
  output logic      scl_out,
  output logic      sda_drv_out
);
  localparam int Q = 64;
  // Idle bus at time zero.
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end
  // Start or repeated start: data falls while clock high.
  task automatic start();
    #Q sda_drv_out = 1'b1;
    #Q scl_out = 1'b1;
    #Q sda_drv_out = 1'b0;
    #Q scl_out = 1'b0;
  endtask
  // Stop: data rises while clock high, after the last acknowledge.
  task automatic stop();
    #Q sda_drv_out = 1'b0;
    #Q scl_out = 1'b1;
    #Q sda_drv_out = 1'b1;
    #Q;
  endtask
  // One clock pulse per bit; data set only while clock low.
  task automatic bit_io(input logic b, output logic r);
    #Q sda_drv_out = b;
    #Q scl_out = 1'b1;
    #Q r = sda_line_in;
    #Q scl_out = 1'b0;
  endtask
  // Eight bits MSB first, then the acknowledge bit.
  task automatic xfer(input logic [7:0] d, input logic m,
                      output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(m, a);
  endtask
endmodule

// ===== tb/i2c_slave_nvm_programmer_tb_top.sv
// Purpose: Self-checking bench for the serial slave with memory programmer.
// Assumes: Host model owns the bus clock; the data line is wired-AND.
// Notes:   Program time is lengthened so reads land while it runs.
`timescale 1ns/1ns
module i2c_slave_nvm_programmer_tb_top;
  localparam logic [6:0] DEV = nvm_i2c_pkg::SLAVE_ADDR;
  typedef struct packed {
    logic [6:0] dev;
    logic [7:0] ptr;
    logic [7:0] dat;
    logic [7:0] exp;
  } row_s;
  row_s       rows[6];
  logic       sys_clk_in;
  logic       reset_in;
  wire  logic scl_w;
  wire  logic hsda_w;
  wire  logic sda_w;
  logic       sda_o;
  logic       oe_n;
  logic       busy;
  logic [7:0] count;
  logic [7:0] rq[$];
  int         fails;
  int         num_checks;
  // Wired-AND data line; the pull-up wins when nobody pulls low.
  assign sda_w = hsda_w & (oe_n | sda_o);
  bus_host_model host (
    .sda_line_in (sda_w),
    .scl_out     (scl_w),
    .sda_drv_out (hsda_w)
  );
  i2c_slave_nvm_programmer #(.REG_COUNT(64), .PROG_CYCLES(8000)) dut (
    .sys_clk_in     (sys_clk_in),
    .reset_in       (reset_in),
    .scl_in         (scl_w),
    .sda_in         (sda_w),
    .sda_out        (sda_o),
    .sda_oe_n_out   (oe_n),
    .prog_busy_out  (busy),
    .prog_count_out (count)
  );
  // System clock with a 4 ns period.
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  // Compares one value and counts it.
  task automatic check(input string n, input logic [7:0] e,
                       input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Start, address with write, then bytes, comparing every acknowledge.
  task automatic seg_w(input logic [6:0] dv, input logic [7:0] b[$]);
    logic [7:0] r;
    logic       a;
    logic [7:0] e;
    e = {7'h00, dv != DEV};
    host.start();
    host.xfer({dv, 1'b0}, 1'b1, r, a);
    check("address ack", e, {7'h00, a});
    foreach (b[i]) begin
      host.xfer(b[i], 1'b1, r, a);
      check("data ack", e, {7'h00, a});
    end
  endtask
  // Repeated start with read; acknowledges all bytes but the last.
  task automatic seg_r(input int n);
    logic [7:0] r;
    logic       a;
    host.start();
    host.xfer({DEV, 1'b1}, 1'b1, r, a);
    check("read ack", 8'h00, {7'h00, a});
    for (int i = 0; i < n; i++) begin
      host.xfer(8'hFF, i == n - 1, r, a);
      rq.push_back(r);
    end
  endtask
  // Writes a pointer and data, then stops.
  task automatic wr(input logic [7:0] b[$]);
    seg_w(DEV, b);
    host.stop();
  endtask
  // Block read of n registers from a pointer.
  task automatic reg_rd(input logic [7:0] p, input int n);
    rq.delete();
    seg_w(DEV, '{p});
    seg_r(n);
    host.stop();
  endtask
  // Sets the memory address once, then reads one memory data register.
  task automatic mem_rd(input logic [7:0] a, input logic [7:0] dr);
    rq.delete();
    seg_w(DEV, '{8'h33, a});
    seg_w(DEV, '{dr});
    seg_r(1);
    host.stop();
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Reset, table of register cases, then the memory and program cases.
  initial begin
    fails = 0;
    num_checks = 0;
    reset_in = 1'b1;
    rows = '{'{DEV, 8'h00, 8'hA5, 8'hA5}, '{DEV, 8'h3F, 8'h3C, 8'h3C},
             '{DEV, 8'h05, 8'h11, 8'h11}, '{7'h58, 8'h05, 8'hEE, 8'h11},
             '{7'h19, 8'h05, 8'h77, 8'h11}, '{DEV, 8'h30, 8'hFF, 8'h00}};
    repeat (20) @(negedge sys_clk_in);
    reset_in = 1'b0;
    repeat (12) @(negedge sys_clk_in);
    check("reset release", 8'h01, {7'h00, oe_n});
    check("reset count", 8'h00, count);
    $display("test reset done");
    foreach (rows[i]) begin
      seg_w(rows[i].dev, '{rows[i].ptr, rows[i].dat});
      host.stop();
      reg_rd(rows[i].ptr, 1);
      check("register", rows[i].exp, rq[0]);
    end
    $display("test table done");
    wr('{8'h08, 8'h01, 8'h02, 8'h03});
    reg_rd(8'h08, 3);
    for (int i = 0; i < 3; i++) check("block", 8'(i + 1), rq[i]);
    wr('{8'h31, 8'h40});
    mem_rd(8'h05, 8'h35);
    check("shadow copy", 8'h11, rq[0]);
    seg_w(DEV, '{8'h33, 8'h20});
    seg_w(DEV, '{8'h35, 8'hC1});
    seg_w(DEV, '{8'h35, 8'hC2});
    host.stop();
    mem_rd(8'h21, 8'h35);
    check("sram next", 8'hC2, rq[0]);
    mem_rd(8'h20, 8'h35);
    check("sram first", 8'hC1, rq[0]);
    $display("test memory done");
    wr('{8'h38, 8'h00});
    wr('{8'h31, 8'h01});
    check("locked busy", 8'h00, {7'h00, busy});
    wr('{8'h38, nvm_i2c_pkg::UNLOCK_KEY});
    wr('{8'h31, 8'h01});
    check("busy pin", 8'h01, {7'h00, busy});
    reg_rd(8'h31, 1);
    check("busy bit", 8'h04, rq[0]);
    mem_rd(8'h20, 8'h34);
    check("blocked read", 8'h00, rq[0]);
    for (int k = 0; k < 12000 && busy !== 1'b0; k++) @(negedge sys_clk_in);
    check("busy end", 8'h00, {7'h00, busy});
    if (busy !== 1'b0) give_verdict();
    check("count pin", 8'h01, count);
    reg_rd(8'h30, 1);
    check("count reg", 8'h01, rq[0]);
    mem_rd(8'h21, 8'h34);
    check("eeprom", 8'hC2, rq[0]);
    wr('{8'h38, 8'h00});
    $display("test program done");
    @(negedge sys_clk_in) reset_in = 1'b1;
    @(negedge sys_clk_in) check("count in reset", 8'h00, count);
    reset_in = 1'b0;
    repeat (12) @(negedge sys_clk_in);
    reg_rd(8'h21, 1);
    check("startup load", 8'hC2, rq[0]);
    $display("test second reset done");
    give_verdict();
  end
endmodule
